/* File: logic/bss_regs.vh */
// bss_regs.vh: constants for the boot source selector and its register window
// assumes inclusion by bare name from logic/ design files
`ifndef BSS_REGS_VH
`define BSS_REGS_VH

// ----------------------------------------------------------------------------
// option word fields
// ----------------------------------------------------------------------------
`define BSS_OPT_SWBOOT_BIT    26
`define BSS_OPT_NBOOT_BIT     27

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define BSS_REG_CTRL          8'h00
`define BSS_REG_STATUS        8'h04
`define BSS_REG_BOOTADDR      8'h08
`define BSS_REG_OPTWORD       8'h0C
`define BSS_REG_NSADDR0       8'h10
`define BSS_REG_NSADDR1       8'h14
`define BSS_REG_SECADDR       8'h18
`define BSS_REG_RSSADDR       8'h1C

// ----------------------------------------------------------------------------
// reset values and status encodings
// ----------------------------------------------------------------------------
`define BSS_RST_NSADDR0       32'h08000000
`define BSS_RST_NSADDR1       32'h0BF90000
`define BSS_RST_SECADDR       32'h0C000000
`define BSS_RST_RSSADDR       32'h0BF80000
`define BSS_RST_OPTWORD       32'h08000000
`define BSS_SRC_NS0           2'h0
`define BSS_SRC_NS1           2'h1
`define BSS_SRC_SEC           2'h2
`define BSS_SRC_RSS           2'h3
`define BSS_RESP_OKAY         2'h0
`define BSS_RESP_SLVERR       2'h2

`endif

/* File: logic/bss_sync3.v */
// bss_sync3.v: three flop synchroniser with agreement filter for a pad level
// assumes the pad is asynchronous to ref_clk
`default_nettype none

module bss_sync3
(
  input  wire ref_clk,   // system clock
  input  wire sys_rst,   // async reset, active high
  input  wire padIn,     // raw pad level
  output reg  levelOut   // filtered level
);

  reg stage1Q;           // metastable stage, read only by stage2Q
  reg stage2Q;           // second stage
  reg stage3Q;           // third stage

  // ----------------------------------------------------------------------------
  // shift chain; level moves only when stage two and three agree
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1Q  <= 1'b0;
      stage2Q  <= 1'b0;
      stage3Q  <= 1'b0;
      levelOut <= 1'b0;
    end
    else
    begin
      stage1Q <= padIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
      if (stage2Q == stage3Q)
      begin
        levelOut <= stage3Q;  // agreement: accept
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/bss_boot_source_selector.v */
// bss_boot_source_selector.v: reset-time boot address selection with AXI4-Lite view
// assumes option bytes and boot addresses are stable from reset until capture,
// and that the core fetch waits for bootValid.
//
// How it works
// - boot select from strap or option bit
// - nonsecure primary address for its two cases
// - nonsecure alternate address for its cases
// - secure address with partitioning on, when locked or plain boot
// - root service entry on select or command, only with partitioning on and unlocked
// - loader image lives in system memory
`default_nettype none
`include "bss_regs.vh"

module bss_boot_source_selector #(
  parameter ADDR_W   = 8,                 // register window address width
  parameter SETTLE_N = 4                  // capture after SETTLE_N+1 settle cycles, covers sync
)
(
  input  wire              ref_clk,       // 25 MHz system clock
  input  wire              sys_rst,       // async reset, active high
  input  wire              bootStrapPad,  // boot strap pad level
  input  wire [31:0]       optionWord,    // nonvolatile option word
  input  wire              securityPartitionEnable, // security partitioning on
  input  wire              bootLock,      // forces secure address when partitioning is on
  input  wire [7:0]        rootSecurityServiceCmd,  // service command
  input  wire [31:0]       nonsecureBootAddrPrimary,
  input  wire [31:0]       nonsecureBootAddrAlternate,
  input  wire [31:0]       secureBootAddr,
  input  wire [31:0]       rootSecurityServiceAddr, // service entry point
  output reg  [31:0]       bootAddr,      // selected fetch address
  output reg               bootValid,     // address captured and held
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam [2:0] ST_SETTLE = 3'b001;    // waiting for strap to settle
  localparam [2:0] ST_CAPT   = 3'b010;    // capture cycle
  localparam [2:0] ST_HOLD   = 3'b100;    // held until next reset

  reg  [2:0]  state_q;                    // one-hot state
  reg  [7:0]  settle_q;                   // settle counter
  reg  [1:0]  src_q;                      // captured source code
  reg         strap_q;                    // captured strap
  reg  [31:0] opt_q;                      // captured option word
  reg  [7:0]  ctrl_q;                     // scratch control, software owned
  wire        strapSync;                  // filtered strap level
  reg  [1:0]  src_d;                      // combinational source choice
  reg         effSel;                     // effective boot select

  // ----------------------------------------------------------------------------
  // strap pad synchroniser
  // ----------------------------------------------------------------------------
  bss_sync3 u_sync
  (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .padIn    (bootStrapPad),
    .levelOut (strapSync)
  );

  // ----------------------------------------------------------------------------
  // source decision
  // ----------------------------------------------------------------------------
  always @*
  begin
    // strap or inverted option bit, chosen by software source bit
    if (optionWord[`BSS_OPT_SWBOOT_BIT])
      effSel = strapSync;
    else
      effSel = ~optionWord[`BSS_OPT_NBOOT_BIT];
    if (!securityPartitionEnable)
    begin
      // partitioning off: primary unless select is high
      src_d = effSel ? `BSS_SRC_NS1 : `BSS_SRC_NS0;
    end
    else if (bootLock)
    begin
      src_d = `BSS_SRC_SEC;
    end
    else if (effSel || (rootSecurityServiceCmd != 8'h00))
    begin
      src_d = `BSS_SRC_RSS;
    end
    else
    begin
      src_d = `BSS_SRC_SEC;
    end
  end

  // address mux; alternate defaults to the loader in system memory
  function [31:0] pickAddr;
    input [1:0] s;
    begin
      case (s)
        `BSS_SRC_NS0: pickAddr = nonsecureBootAddrPrimary;
        `BSS_SRC_NS1: pickAddr = nonsecureBootAddrAlternate;
        `BSS_SRC_SEC: pickAddr = secureBootAddr;
        default:      pickAddr = rootSecurityServiceAddr;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------------
  // capture sequence: one sample after release, then frozen
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q   <= ST_SETTLE;
      settle_q  <= 8'h00;
      src_q     <= `BSS_SRC_NS0;
      strap_q   <= 1'b0;
      opt_q     <= `BSS_RST_OPTWORD;
      bootAddr  <= `BSS_RST_NSADDR0;
      bootValid <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_SETTLE:
        begin
          // wait for synchroniser depth before trusting the strap
          settle_q <= settle_q + 8'h01;
          if (settle_q == SETTLE_N[7:0])
            state_q <= ST_CAPT;
        end
        ST_CAPT:
        begin
          src_q     <= src_d;
          strap_q   <= strapSync;
          opt_q     <= optionWord;
          bootAddr  <= pickAddr(src_d);
          bootValid <= 1'b1;
          state_q   <= ST_HOLD;
        end
        ST_HOLD:
        begin
          state_q <= ST_HOLD;      // nothing changes until sys_rst
        end
        default:
        begin
          state_q <= ST_SETTLE;    // recover from illegal code
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // axi4-lite write: take address and data together, respond next cycle
  // ----------------------------------------------------------------------------
  wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wrGo;            // both taken in one edge
  assign s_axi_wready  = wrGo;

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q       <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BSS_RESP_OKAY;
    end
    else
    begin
      if (wrGo)
      begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_awaddr == `BSS_REG_CTRL)
        begin
          // only the scratch byte is writable; captured state is immune
          if (s_axi_wstrb[0])
            ctrl_q <= s_axi_wdata[7:0];
          s_axi_bresp <= `BSS_RESP_OKAY;
        end
        else if (s_axi_awaddr <= `BSS_REG_RSSADDR && s_axi_awaddr[1:0] == 2'b00)
          s_axi_bresp <= `BSS_RESP_SLVERR;   // read-only register
        else
          s_axi_bresp <= `BSS_RESP_SLVERR;   // unmapped
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // axi4-lite read: one cycle latency
  // ----------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `BSS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && !s_axi_rvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `BSS_RESP_OKAY;
        if (s_axi_araddr == `BSS_REG_CTRL)
          s_axi_rdata <= {24'h000000, ctrl_q};
        else if (s_axi_araddr == `BSS_REG_STATUS)
          s_axi_rdata <= {27'h0000000, strap_q, src_q, bootValid, state_q[2]};
        else if (s_axi_araddr == `BSS_REG_BOOTADDR)
          s_axi_rdata <= bootAddr;
        else if (s_axi_araddr == `BSS_REG_OPTWORD)
          s_axi_rdata <= opt_q;
        else if (s_axi_araddr == `BSS_REG_NSADDR0)
          s_axi_rdata <= nonsecureBootAddrPrimary;
        else if (s_axi_araddr == `BSS_REG_NSADDR1)
          s_axi_rdata <= nonsecureBootAddrAlternate;
        else if (s_axi_araddr == `BSS_REG_SECADDR)
          s_axi_rdata <= secureBootAddr;
        else if (s_axi_araddr == `BSS_REG_RSSADDR)
          s_axi_rdata <= rootSecurityServiceAddr;
        else
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BSS_RESP_SLVERR;   // unmapped
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: verification/bss_opt_model.sv */
// bss_opt_model.sv: strap pad and option byte source for the selector
// assumes the bench sets levels while reset is high and holds them to capture
`default_nettype none
`include "bss_regs.vh"
// ----------------------------------------------------------------------------
// option byte and strap model
// ----------------------------------------------------------------------------
module bss_opt_model
(
  input  wire logic        strapLevel,                 // pad level to present
  input  wire logic        swSel,                      // software source bit
  input  wire logic        invSel,                     // inverted boot bit
  output wire logic        bootStrapPad,               // strap pad
  output wire logic [31:0] optionWord,                 // option word
  output wire logic [31:0] nonsecureBootAddrPrimary,   // factory values
  output wire logic [31:0] nonsecureBootAddrAlternate,
  output wire logic [31:0] secureBootAddr,
  output wire logic [31:0] rootSecurityServiceAddr
);
  timeunit 1ns;
  timeprecision 1ns;
  // pad driven hard, no pull needed
  assign bootStrapPad = strapLevel;
  // only bits 27 and 26 vary; other bits keep a fixed pattern
  assign optionWord = {4'h0, invSel, swSel, 26'h0} | 32'h30000001;
  assign nonsecureBootAddrPrimary = `BSS_RST_NSADDR0;
  assign nonsecureBootAddrAlternate = `BSS_RST_NSADDR1;
  assign secureBootAddr = `BSS_RST_SECADDR;
  assign rootSecurityServiceAddr = `BSS_RST_RSSADDR;
endmodule
`default_nettype wire

/* File: verification/bss_boot_source_selector_sva.sv */
// bss_boot_source_selector_sva.sv: capture and hold checks on the selector ports
// assumes straps and options stay stable from reset until capture
`default_nettype none
// ----------------------------------------------------------------------------
// checker
// ----------------------------------------------------------------------------
module bss_sel_chk
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [31:0] optionWord,
  input wire logic        bootStrapPad,
  input wire logic        securityPartitionEnable,
  input wire logic        bootLock,
  input wire logic [7:0]  rootSecurityServiceCmd,
  input wire logic [31:0] nonsecureBootAddrPrimary,
  input wire logic [31:0] nonsecureBootAddrAlternate,
  input wire logic [31:0] secureBootAddr,
  input wire logic [31:0] rootSecurityServiceAddr,
  input wire logic [31:0] bootAddr,
  input wire logic        bootValid
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic sel;  // effective select: strap or inverted option bit
  wire logic svc;  // service requested
  assign sel = optionWord[26] ? bootStrapPad : !optionWord[27];
  assign svc = sel || (rootSecurityServiceCmd != 8'h00);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // wide window: synchroniser depth may vary by a cycle
  boot_late_a: assert property ($fell(sys_rst) |-> !bootValid[*5] ##[1:8] bootValid)
    else $error("boot capture timing wrong");
  valid_hold_a: assert property (bootValid |=> bootValid)
    else $error("capture flag dropped");
  addr_hold_a: assert property (bootValid |=> $stable(bootAddr))
    else $error("boot address moved after capture");
  opt_sel_a: assert property ($rose(bootValid) && !securityPartitionEnable && !optionWord[26]
    |-> bootAddr == (optionWord[27] ? nonsecureBootAddrPrimary : nonsecureBootAddrAlternate))
    else $error("option bit source wrong");
  ns_prim_a: assert property ($rose(bootValid) && !securityPartitionEnable && !sel
    |-> bootAddr == nonsecureBootAddrPrimary)
    else $error("primary address not chosen");
  ns_alt_a: assert property ($rose(bootValid) && !securityPartitionEnable && sel
    |-> bootAddr == nonsecureBootAddrAlternate)
    else $error("alternate address not chosen");
  sec_boot_a: assert property ($rose(bootValid) && securityPartitionEnable && (bootLock || !svc)
    |-> bootAddr == secureBootAddr)
    else $error("secure address not chosen");
  svc_entry_a: assert property ($rose(bootValid) && securityPartitionEnable && !bootLock && svc
    |-> bootAddr == rootSecurityServiceAddr)
    else $error("service entry not chosen");
  cover property ($rose(bootValid) && !securityPartitionEnable);
  cover property ($rose(bootValid) && securityPartitionEnable && bootLock);
  cover property ($rose(bootValid) && securityPartitionEnable && !bootLock && svc);
endmodule
bind bss_boot_source_selector bss_sel_chk chk (.*);
`default_nettype wire

/* File: verification/bss_boot_source_selector_test.sv */
// bss_boot_source_selector_test.sv: directed bench, one reset per boot case
// assumes the option model, checker and design are compiled before it
`default_nettype none
`include "bss_regs.vh"
module bss_boot_source_selector_test;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic ref_clk = 1'b0, sys_rst = 1'b1, strapLevel = 1'b0, swSel = 1'b1, invSel = 1'b1;
  logic securityPartitionEnable = 1'b0, bootLock = 1'b0;
  logic [7:0] rootSecurityServiceCmd = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;  // full words until lane 0 is masked
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic bootStrapPad, bootValid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [31:0] optionWord, nonsecureBootAddrPrimary, nonsecureBootAddrAlternate, secureBootAddr;
  wire logic [31:0] rootSecurityServiceAddr, bootAddr, s_axi_rdata;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  int errorCnt = 0, nChecks = 0, n;
  logic [31:0] d;
  logic [1:0] r, src;
  logic [31:0] expAddr [4] = '{`BSS_RST_NSADDR0, `BSS_RST_NSADDR1, `BSS_RST_SECADDR, `BSS_RST_RSSADDR};
  // cases: {source, partition, lock, command, strap, sw bit, inverted bit}
  logic [7:0] cases [11] = '{8'h02, 8'h47, 8'h01, 8'h44, 8'hA2, 8'hE7, 8'hA5, 8'hE0, 8'hE9, 8'hBF, 8'hB2};
  always #20 ref_clk = ~ref_clk;
  bss_opt_model opt (.*);
  bss_boot_source_selector uut (.*);
  // --------------------------------------------------------------------------
  // bus tasks: hold each request until ready is seen at an edge
  // --------------------------------------------------------------------------
  // each task starts on a fresh rising edge, so back-to-back calls never
  // drive one signal twice in a time step; no cycle count is assumed, the
  // watchdog alone ends a wait that never sees its answer
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic awPend;
    logic wPend;
    awPend = 1'b1;
    wPend = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // address and data each drop at the edge that takes them
    while (awPend || wPend)
    begin
      @(posedge ref_clk);
      if (awPend && s_axi_awready === 1'b1)
      begin
        awPend = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wPend && s_axi_wready === 1'b1)
      begin
        wPend = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    // response taken at the edge where bvalid meets bready
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // data taken at the edge where rvalid meets rready
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    nChecks++;
    if (got !== want)
    begin
      errorCnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic finishTest;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axw(`BSS_REG_CTRL, 32'h123456A5, r);
    chk({30'h0, r}, {30'h0, `BSS_RESP_OKAY});
    axr(`BSS_REG_CTRL, d, r);
    chk(d, 32'h000000A5);  // scratch keeps low byte only
    s_axi_wstrb <= 4'hE;  // lane 0 masked: scratch must not move
    axw(`BSS_REG_CTRL, 32'h0000005A, r);
    chk({30'h0, r}, {30'h0, `BSS_RESP_OKAY});
    axr(`BSS_REG_CTRL, d, r);
    chk(d, 32'h000000A5);
    axw(`BSS_REG_NSADDR0, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, `BSS_RESP_SLVERR});
    axr(8'h20, d, r);
    chk(d, 32'h00000000);
    chk({30'h0, r}, {30'h0, `BSS_RESP_SLVERR});
    // each case needs its own reset since capture happens once
    foreach (cases[i])
    begin
      // command bit lands in the low bit; upper command bits cleared in the same write
      {src, securityPartitionEnable, bootLock, rootSecurityServiceCmd, strapLevel, swSel, invSel}
        <= {cases[i][7:4], 7'h00, cases[i][3:0]};
      sys_rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (n = 0; n < 20 && bootValid !== 1'b1; n++) @(negedge ref_clk);
      chk({31'h0, bootValid}, 32'h00000001);
      chk(bootAddr, expAddr[src]);
      axr(`BSS_REG_STATUS, d, r);
      chk(d, {27'h0, strapLevel, src, 2'h3});
      axr(`BSS_REG_BOOTADDR, d, r);
      chk(d, expAddr[src]);
      // flip strap, option, partition and lock inputs and set command to 8'h80 after capture; nothing captured may follow
      {securityPartitionEnable, bootLock, rootSecurityServiceCmd, strapLevel, swSel, invSel}
        <= {~cases[i][5:4], 8'h80, ~cases[i][2:0]};
      repeat (9) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(bootAddr, expAddr[src]);
      axr(`BSS_REG_OPTWORD, d, r);
      chk(d, {4'h3, cases[i][0], cases[i][1], 25'h0, 1'b1});
    end
    finishTest;
  end
  // watchdog well beyond the expected run of about 340 cycles
  initial
  begin
    #200000;
    errorCnt++;
    finishTest;
  end
endmodule
`default_nettype wire
